// >>> inc/lcd_host_pkg.sv
// Operation
// RULE_01: Parallel mode from strap and upper lines.
// RULE_02: Serial variant from strap and upper lines.
// RULE_03: Four-bit modes use only lower lines.
// RULE_04: Serial clock on line 0, data line 3.
// RULE_05: Respond only while both selects are active.
// RULE_06: Deselected device never drives the data lines. Here the read drive stays on for one clock after the select drops.
// RULE_07: I2C mode: selects give address bits 3,2.
// RULE_08: Nine-bit and I2C ignore control/data pin.
// RULE_09: Status read returns identity strap in bit 7.
// RULE_10: Selector low is control, high is data.
// RULE_11: Strobe pins meaning follows processor convention.
// RULE_12: Nibble transfers move high nibble first.
package lcd_host_pkg;

  typedef enum logic [2:0] {
    MODE_P8_8080 = 3'b000,
    MODE_P8_6800 = 3'b001,
    MODE_P4_8080 = 3'b010,
    MODE_P4_6800 = 3'b011,
    MODE_S8_STD = 3'b100,
    MODE_S8_VND = 3'b101,
    MODE_S9 = 3'b110,
    MODE_I2C = 3'b111
  } bus_mode_t;

  // Strap codes and upper data line codes used by the mode decoder.
  localparam logic [1:0] STRAP_P8_8080 = 2'h2;
  localparam logic [1:0] STRAP_P8_6800 = 2'h3;
  localparam logic [1:0] STRAP_LOW_8080 = 2'h0;
  localparam logic [1:0] STRAP_LOW_6800 = 2'h1;
  localparam logic [1:0] UPPER_SERIAL_A = 2'h2;
  localparam logic [1:0] UPPER_SERIAL_B = 2'h3;

  // Word layout: control/data flag above the byte.
  localparam int WORD_W = 9;
  localparam int FIFO_DEPTH = 16;

  // Bit counter positions on the link.
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [3:0] S9_LAST_BIT = 4'h8;
  localparam logic [3:0] I2C_ACK_BIT = 4'h8;

  // Upper three I2C address bits; the value is arbitrary.
  localparam logic [2:0] I2C_ADDR_HIGH = 3'h3;
  localparam logic I2C_ADDR_BIT0 = 1'b0;

  // Values after reset.
  localparam logic [15:0] PIN_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [8:0] WORD_RESET = 9'h000;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [3:0] BITCNT_RESET = 4'h0;

endpackage : lcd_host_pkg

// >>> inc/byte_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
// Valid/ready word stream between the front end and its buffer.
interface byte_stream_if #(parameter int WIDTH = 9);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// >>> rtl/word_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  byte_stream_if.sink push,
  output logic popValid,
  input wire logic popReady,
  output logic [WIDTH-1:0] popData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  logic full;
  logic empty;

  // Pointers carry one extra wrap bit so full and empty differ.
  assign empty = (wrPtr == rdPtr);
  assign full = (wrPtr[AW-1:0] == rdPtr[AW-1:0]) && (wrPtr[AW] != rdPtr[AW]);
  assign push.ready = !full;
  assign popValid = !empty;
  assign popData = mem[rdPtr[AW-1:0]];

  // Write side.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
    end else if (push.valid && !full) begin
      wrPtr <= wrPtr + 1'b1;
    end
  end

  // Storage has no reset; only written slots are ever read.
  always_ff @(posedge clk_sys) begin
    if (push.valid && !full) begin
      mem[wrPtr[AW-1:0]] <= push.data;
    end
  end

  // Read side.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdPtr <= '0;
    end else if (popReady && !empty) begin
      rdPtr <= rdPtr + 1'b1;
    end
  end

endmodule : word_fifo
`default_nettype wire

// >>> rtl/lcd_host_interface_select.sv
`timescale 1ns/100ps
`default_nettype none
module lcd_host_interface_select (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic [1:0] busModeStrap,
  input wire logic selectHighActive,
  input wire logic selectLowActive,
  input wire logic controlDataSelect,
  input wire logic identityStrap,
  input wire logic [1:0] writeReadCtl,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic [7:0] dataOe,
  input wire logic [6:0] statusBits,
  input wire logic [7:0] readData,
  output logic [7:0] hostByte,
  output logic hostByteIsData,
  output logic hostByteValid,
  input wire logic hostByteReady,
  output logic [2:0] activeMode,
  output logic overflow
);
  lcd_host_pkg::bus_mode_t busMode;
  lcd_host_pkg::bus_mode_t next_busMode;
  logic [15:0] pinMeta;
  logic [15:0] pinSync;
  logic [15:0] pinPrev;
  logic [1:0] primed;
  logic [1:0] strapS;
  logic csHighS;
  logic csLowS;
  logic cdS;
  logic cdPrev;
  logic idS;
  logic [1:0] wrS;
  logic [1:0] wrPrev;
  logic [7:0] dataS;
  logic [7:0] dataPrev;
  logic isPar;
  logic isNibble;
  logic is6800;
  logic isSpi;
  logic isS9;
  logic isI2c;
  logic selected;
  logic writeEnd;
  logic readNow;
  logic writeStrobe;
  logic readStart;
  logic readDone;
  logic readDrive;
  logic nibblePhase;
  logic [3:0] nibbleHold;
  logic [7:0] readSource;
  logic [7:0] readHold;
  logic [7:0] outByte;
  logic newValid;
  logic [8:0] newWord;
  logic pushValid;
  logic [8:0] pushWord;
  logic i2cStart;
  logic i2cStop;
  logic i2cActive;
  logic i2cFirst;
  logic i2cOk;
  logic i2cCd;
  logic linkRun;
  logic togMeta;
  logic togSync;
  logic togPrev;
  logic wordEvent;
  // Link domain signals.
  logic [3:0] lnkMeta;
  logic [3:0] lnkSync;
  logic isS9L;
  logic isI2cL;
  logic linkClear_n;
  logic sdaLink;
  logic [3:0] bitCnt;
  logic [3:0] lastBit;
  logic [3:0] dataLast;
  logic [8:0] shiftReg;
  logic [8:0] assembled;
  logic storeNow;
  logic firstByte;
  logic addrOk;
  logic [8:0] linkWord;
  logic linkToggle;
  logic ackDrive;

  byte_stream_if #(.WIDTH(lcd_host_pkg::WORD_W)) fifoIn ();

  // Every pin passes two flip-flops; pinPrev holds the sample before.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= lcd_host_pkg::PIN_RESET;
      pinSync <= lcd_host_pkg::PIN_RESET;
      pinPrev <= lcd_host_pkg::PIN_RESET;
    end else begin
      pinMeta <= {busModeStrap, selectHighActive, selectLowActive,
                  controlDataSelect, identityStrap, writeReadCtl, dataIn};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  // Edges are trusted from the second clock after reset, once pinSync holds a real sample.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      primed <= 2'h0;
    end else begin
      primed <= {primed[0], 1'b1};
    end
  end

  assign strapS = pinSync[15:14];
  assign csHighS = pinSync[13];
  assign csLowS = pinSync[12];
  assign cdS = pinSync[11];
  assign cdPrev = pinPrev[11];
  assign idS = pinSync[10];
  assign wrS = pinSync[9:8];
  assign wrPrev = pinPrev[9:8];
  assign dataS = pinSync[7:0];
  assign dataPrev = pinPrev[7:0];

  // Mode decoder from the strap and the two upper data lines.
  always_comb begin
    case (strapS)
      lcd_host_pkg::STRAP_P8_8080: next_busMode = lcd_host_pkg::MODE_P8_8080; // RULE_01
      lcd_host_pkg::STRAP_P8_6800: next_busMode = lcd_host_pkg::MODE_P8_6800; // RULE_01
      lcd_host_pkg::STRAP_LOW_8080: begin
        case (dataS[7:6])
          lcd_host_pkg::UPPER_SERIAL_A: next_busMode = lcd_host_pkg::MODE_S8_STD; // RULE_02
          lcd_host_pkg::UPPER_SERIAL_B: next_busMode = lcd_host_pkg::MODE_S8_VND; // RULE_02
          default: next_busMode = lcd_host_pkg::MODE_P4_8080; // RULE_01
        endcase
      end
      lcd_host_pkg::STRAP_LOW_6800: begin
        case (dataS[7:6])
          lcd_host_pkg::UPPER_SERIAL_A: next_busMode = lcd_host_pkg::MODE_S9; // RULE_02
          lcd_host_pkg::UPPER_SERIAL_B: next_busMode = lcd_host_pkg::MODE_I2C; // RULE_02
          default: next_busMode = lcd_host_pkg::MODE_P4_6800; // RULE_01
        endcase
      end
      default: next_busMode = lcd_host_pkg::MODE_P8_8080;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busMode <= lcd_host_pkg::MODE_P8_8080;
    end else begin
      busMode <= next_busMode;
    end
  end

  assign activeMode = busMode;
  assign isPar = (busMode[2] == 1'b0);
  assign isNibble = (busMode == lcd_host_pkg::MODE_P4_8080) ||
                    (busMode == lcd_host_pkg::MODE_P4_6800);
  assign is6800 = (busMode == lcd_host_pkg::MODE_P8_6800) ||
                  (busMode == lcd_host_pkg::MODE_P4_6800);
  assign isS9 = (busMode == lcd_host_pkg::MODE_S9);
  assign isI2c = (busMode == lcd_host_pkg::MODE_I2C);
  assign isSpi = busMode[2] && !isI2c;
  // The select pins are address straps in I2C mode, never selects.
  assign selected = csHighS && !csLowS && !isI2c; // RULE_05 RULE_07

  // Strobe meaning depends on the processor convention.
  always_comb begin
    if (is6800) begin
      writeEnd = wrPrev[1] && !wrS[1] && !wrPrev[0]; // RULE_11
      readNow = wrS[1] && wrS[0]; // RULE_11
    end else begin
      writeEnd = !wrPrev[0] && wrS[0]; // RULE_11
      readNow = !wrS[1]; // RULE_11
    end
  end

  assign writeStrobe = writeEnd && selected && isPar && primed[1]; // RULE_05
  assign readStart = readNow && selected && isPar && primed[1] && !readDrive;
  assign readDone = readDrive && !(readNow && selected);

  // Read drive is registered from the strobe and drops one clock after select goes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      readDrive <= 1'b0;
    end else begin
      readDrive <= readNow && selected && isPar && primed[1]; // RULE_05 RULE_06
    end
  end

  // Nibble phase advances on every write and every finished read.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nibblePhase <= 1'b0;
      nibbleHold <= lcd_host_pkg::NIBBLE_RESET;
    end else if (!isNibble) begin
      nibblePhase <= 1'b0;
    end else if (writeStrobe) begin
      nibblePhase <= !nibblePhase; // RULE_12
      if (!nibblePhase) begin
        nibbleHold <= dataPrev[3:0]; // RULE_12
      end
    end else if (readDone) begin
      nibblePhase <= !nibblePhase; // RULE_12
    end
  end

  // Control reads give status with the identity strap on top.
  assign readSource = cdS ? readData : {idS, statusBits}; // RULE_09 RULE_10

  // Output byte; nibble reads present the high half first.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      outByte <= lcd_host_pkg::BYTE_RESET;
      readHold <= lcd_host_pkg::BYTE_RESET;
    end else if (!isPar) begin
      outByte <= lcd_host_pkg::BYTE_RESET;
    end else if (readStart) begin
      if (!isNibble) begin
        outByte <= readSource;
      end else if (!nibblePhase) begin
        outByte <= {4'h0, readSource[7:4]}; // RULE_03 RULE_12
        readHold <= readSource;
      end else begin
        outByte <= {4'h0, readHold[3:0]}; // RULE_03 RULE_12
      end
    end
  end

  // Only the read drive or the I2C acknowledge turns drivers on.
  assign dataOut = outByte;
  always_comb begin
    if (readDrive) begin
      dataOe = isNibble ? 8'h0F : 8'hFF; // RULE_03
    end else begin
      dataOe = {4'h0, ackDrive, 3'h0}; // RULE_06
    end
  end

  // I2C start and stop seen on the synchronised clock and data lines.
  assign i2cStart = isI2c && primed[1] && dataS[0] && pinPrev[3] && !dataS[3];
  assign i2cStop = isI2c && primed[1] && dataS[0] && !pinPrev[3] && dataS[3];

  // Word arrival from the link domain by toggle crossing.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      togMeta <= 1'b0;
      togSync <= 1'b0;
      togPrev <= 1'b0;
    end else begin
      togMeta <= linkToggle;
      togSync <= togMeta;
      togPrev <= togSync;
    end
  end
  assign wordEvent = togSync ^ togPrev;

  // I2C frame state: address byte, then data bytes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      i2cActive <= 1'b0;
      i2cFirst <= 1'b0;
      i2cOk <= 1'b0;
      i2cCd <= 1'b0;
    end else if (!isI2c || i2cStop) begin
      i2cActive <= 1'b0;
    end else if (i2cStart) begin
      i2cActive <= 1'b1;
      i2cFirst <= 1'b1;
      i2cOk <= 1'b0;
    end else if (wordEvent && i2cActive && i2cFirst) begin
      i2cFirst <= 1'b0;
      i2cOk <= linkWord[8]; // RULE_07
      i2cCd <= linkWord[2]; // RULE_08
    end
  end

  // Link logic runs only inside a frame; a restart clears it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      linkRun <= 1'b0;
    end else begin
      linkRun <= (isSpi && csHighS && !csLowS) || // RULE_05
                 (isI2c && i2cActive && !i2cStart);
    end
  end

  // Word selection from the parallel bus or the serial link.
  always_comb begin
    newValid = 1'b0;
    newWord = lcd_host_pkg::WORD_RESET;
    if (writeStrobe && (!isNibble || nibblePhase)) begin
      newValid = 1'b1;
      newWord = {cdPrev, isNibble ? {nibbleHold, dataPrev[3:0]} : dataPrev}; // RULE_10 RULE_12
    end else if (wordEvent && isSpi) begin
      newValid = 1'b1;
      newWord = isS9 ? linkWord : {cdS, linkWord[7:0]}; // RULE_08 RULE_10
    end else if (wordEvent && i2cActive && !i2cFirst && i2cOk) begin
      newValid = 1'b1;
      newWord = {i2cCd, linkWord[7:0]}; // RULE_08
    end
  end

  // One-word holding stage; it waits while the buffer is full.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pushValid <= 1'b0;
      pushWord <= lcd_host_pkg::WORD_RESET;
    end else if (newValid && (!pushValid || fifoIn.ready)) begin
      pushValid <= 1'b1;
      pushWord <= newWord;
    end else if (fifoIn.ready) begin
      pushValid <= 1'b0;
    end
  end

  // Sticky flag for a word lost behind a stalled buffer.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overflow <= 1'b0;
    end else if (newValid && pushValid && !fifoIn.ready) begin
      overflow <= 1'b1;
    end
  end

  assign fifoIn.valid = pushValid;
  assign fifoIn.data = pushWord;

  word_fifo #(.WIDTH(lcd_host_pkg::WORD_W), .DEPTH(lcd_host_pkg::FIFO_DEPTH)) buffer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .push(fifoIn),
    .popValid(hostByteValid),
    .popReady(hostByteReady),
    .popData({hostByteIsData, hostByte})
  );

  // Mode bits and address straps brought onto the link clock.
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      lnkMeta <= 4'h0;
      lnkSync <= 4'h0;
    end else begin
      lnkMeta <= {isS9, isI2c, selectHighActive, selectLowActive};
      lnkSync <= lnkMeta;
    end
  end
  assign isS9L = lnkSync[3];
  assign isI2cL = lnkSync[2];

  // Serial data always on line 3, sampled on the rising link clock.
  assign sdaLink = dataIn[3]; // RULE_04
  assign linkClear_n = rst_n && linkRun;
  assign lastBit = (isS9L || isI2cL) ? lcd_host_pkg::S9_LAST_BIT
                                     : lcd_host_pkg::BYTE_LAST_BIT;
  assign dataLast = isS9L ? lcd_host_pkg::S9_LAST_BIT
                          : lcd_host_pkg::BYTE_LAST_BIT;
  assign assembled = {shiftReg[7:0], sdaLink};
  assign storeNow = (bitCnt == dataLast);
  assign addrOk = (assembled[7:5] == lcd_host_pkg::I2C_ADDR_HIGH) &&
                  (assembled[4] == lnkSync[1]) && (assembled[3] == lnkSync[0]) &&
                  (assembled[1] == lcd_host_pkg::I2C_ADDR_BIT0) && !assembled[0]; // RULE_07

  // Bit counter and shifter, cleared whenever no frame is open.
  always_ff @(posedge linkClk or negedge linkClear_n) begin
    if (!linkClear_n) begin
      bitCnt <= lcd_host_pkg::BITCNT_RESET;
      shiftReg <= lcd_host_pkg::WORD_RESET;
      firstByte <= 1'b1;
    end else begin
      shiftReg <= assembled;
      if (bitCnt == lastBit) begin
        bitCnt <= lcd_host_pkg::BITCNT_RESET;
        firstByte <= 1'b0;
      end else begin
        bitCnt <= bitCnt + 1'b1;
      end
    end
  end

  // Finished words outlive the frame so a late crossing is not lost.
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      linkWord <= lcd_host_pkg::WORD_RESET;
      linkToggle <= 1'b0;
    end else if (linkRun && storeNow) begin
      linkWord <= isI2cL ? {addrOk, assembled[7:0]} : assembled; // RULE_08
      linkToggle <= !linkToggle;
    end
  end

  // Acknowledge pulls line 3 low through the ninth clock.
  always_ff @(negedge linkClk or negedge linkClear_n) begin
    if (!linkClear_n) begin
      ackDrive <= 1'b0;
    end else begin
      ackDrive <= isI2cL && (bitCnt == lcd_host_pkg::I2C_ACK_BIT) &&
                  (!firstByte || linkWord[8]);
    end
  end

  mode_8080_a: assert property ( // RULE_01
    @(posedge clk_sys) disable iff (!rst_n)
    (strapS == lcd_host_pkg::STRAP_P8_8080) |=> (busMode == lcd_host_pkg::MODE_P8_8080))
    else $error("Strap 10 did not select 8-bit 8080 mode.");

  mode_i2c_a: assert property ( // RULE_02
    @(posedge clk_sys) disable iff (!rst_n)
    (strapS == lcd_host_pkg::STRAP_LOW_6800 && dataS[7:6] == lcd_host_pkg::UPPER_SERIAL_B)
    |=> isI2c)
    else $error("Strap 01 with upper 11 did not select I2C.");

  nibble_lines_a: assert property ( // RULE_03
    @(posedge clk_sys) disable iff (!rst_n)
    isNibble |-> (dataOe[7:4] == 4'h0))
    else $error("Upper data lines driven in 4-bit mode.");

  select_push_a: assert property ( // RULE_05
    @(posedge clk_sys) disable iff (!rst_n)
    ($rose(pushValid) && isPar && $past(isPar)) |-> $past(selected))
    else $error("Parallel word taken while not selected.");

  deselect_hiz_a: assert property ( // RULE_06
    @(posedge clk_sys) disable iff (!rst_n)
    (!selected && !isI2c) [*2] |-> (dataOe == 8'h00))
    else $error("Data lines driven while deselected.");

  addr_strap_a: assert property ( // RULE_07
    @(posedge linkClk) disable iff (!rst_n)
    (linkRun && storeNow && isI2cL && assembled[4] != lnkSync[1]) |=> !linkWord[8])
    else $error("I2C address accepted with wrong bit 3.");

  s9_cd_bit_a: assert property ( // RULE_08
    @(posedge clk_sys) disable iff (!rst_n)
    (wordEvent && isS9 && !writeStrobe && (!pushValid || fifoIn.ready))
    |=> (pushWord[8] == $past(linkWord[8])))
    else $error("Nine-bit word did not take its own control bit.");

  status_id_a: assert property ( // RULE_09
    @(posedge clk_sys) disable iff (!rst_n)
    (readStart && !cdS && !isNibble) |=> (dataOut[7] == $past(idS)))
    else $error("Status read lost the identity strap.");

  data_read_a: assert property ( // RULE_10
    @(posedge clk_sys) disable iff (!rst_n)
    (readStart && cdS && !isNibble) |=> (dataOut == $past(readData)))
    else $error("Data read did not return the display byte.");

  rw_6800_a: assert property ( // RULE_11
    @(posedge clk_sys) disable iff (!rst_n)
    ($rose(readDrive) && is6800) |-> $past(wrS[0] && wrS[1]))
    else $error("6800 read driven without enable and read select.");

  nibble_pair_a: assert property ( // RULE_12
    @(posedge clk_sys) disable iff (!rst_n)
    ($rose(pushValid) && isNibble && $past(writeStrobe)) |-> $past(nibblePhase))
    else $error("4-bit byte taken after a single nibble.");

endmodule : lcd_host_interface_select
`default_nettype wire

// >>> dv/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host processor model; drives strap, select, strobe and data pins.
module host_model (
  input wire logic clk_sys,
  input wire logic [7:0] dataOut,
  input wire logic [7:0] dataOe,
  output logic [7:0] dataIn,
  output logic [1:0] strap,
  output logic selHi,
  output logic selLo,
  output logic cd,
  output logic [1:0] ctl
);
  logic [7:0] hostD = 8'h00;
  logic [7:0] hostOe = 8'hFF;
  logic [7:0] lastD = 8'h00;
  // A line nobody drives shows the inverse of its last value.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dataIn[i] = dataOe[i] ? dataOut[i] : hostOe[i] ? hostD[i] : ~lastD[i];
    end
  end
  // Pins at time zero: 8-bit parallel, not selected.
  initial begin
    strap = 2'h2;
    selHi = 1'h0;
    selLo = 1'h1;
    cd = 1'h0;
    ctl = 2'h3;
  end
  // Straps a bus mode and lets the decoder settle.
  task automatic setMode(input logic [1:0] s, input logic [1:0] u,
      input logic [1:0] idle);
    @(negedge clk_sys);
    strap = s;
    hostD = {u, 6'h00};
    ctl = idle;
    repeat (8) @(negedge clk_sys);
  endtask : setMode
  // Selects or releases the device.
  task automatic sel(input logic on);
    @(negedge clk_sys);
    selHi = on;
    selLo = !on;
    repeat (4) @(negedge clk_sys);
  endtask : sel
  // One strobe; request and data hold five cycles in each phase.
  task automatic cyc(input logic [1:0] act, input logic [1:0] idle,
      input logic [7:0] d, input logic [7:0] keep, input logic c,
      output logic [7:0] q);
    @(negedge clk_sys);
    hostD = d;
    lastD = d;
    hostOe = keep;
    cd = c;
    ctl = act;
    repeat (5) @(negedge clk_sys);
    q = dataIn;
    ctl = idle;
    repeat (5) @(negedge clk_sys);
    hostOe = 8'hFF;
  endtask : cyc
  // Serial frame, MSB first; the link clock runs only inside it.
  task automatic spi(input logic [8:0] w, input int n);
    sel(1'h1);
    for (int i = n - 1; i >= 0; i--) begin
      hostD[3] = w[i];
      #6 hostD[0] = 1'h1;
      #6 hostD[0] = 1'h0;
    end
    repeat (12) @(negedge clk_sys);
    sel(1'h0);
  endtask : spi
endmodule : host_model
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Compares two values, counts it, and reports a mismatch.
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  n_fail++; $display("[FAIL] %0t got %h want %h", $time, got, exp); end end
module tb_top;
  logic clk_sys, rst_n, selHi, selLo, cd, identityStrap;
  logic [1:0] strap, ctl;
  logic [7:0] dataIn, dataOut, dataOe, readData, hostByte, q;
  logic [6:0] statusBits;
  logic isData, hostByteValid, hostByteReady, overflow;
  logic [2:0] activeMode;
  int n_fail = 0;
  int n_compared = 0;
  // Device under test; the link clock is data line 0.
  lcd_host_interface_select lcd_host_interface_select_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .linkClk(dataIn[0]),
    .busModeStrap(strap), .selectHighActive(selHi),
    .selectLowActive(selLo), .controlDataSelect(cd),
    .identityStrap(identityStrap), .writeReadCtl(ctl),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .statusBits(statusBits), .readData(readData),
    .hostByte(hostByte), .hostByteIsData(isData),
    .hostByteValid(hostByteValid), .hostByteReady(hostByteReady),
    .activeMode(activeMode), .overflow(overflow));
  // Host on the far side of the pins.
  host_model host_model_inst (.clk_sys(clk_sys), .dataOut(dataOut),
    .dataOe(dataOe), .dataIn(dataIn), .strap(strap), .selHi(selHi),
    .selLo(selLo), .cd(cd), .ctl(ctl));
  // System clock, 8 ns period.
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Waits for a received word, compares it, then pops it.
  task automatic popChk(input logic [7:0] b, input logic isD);
    int k;
    k = 0;
    while (hostByteValid !== 1'h1 && k < 40) begin
      @(negedge clk_sys);
      k++;
    end
    `CHK(hostByteValid, 1'h1)
    `CHK(hostByte, b)
    `CHK(isData, isD)
    hostByteReady = 1'h1;
    @(negedge clk_sys);
    hostByteReady = 1'h0;
    @(negedge clk_sys);
  endtask : popChk
  // One parallel write strobe.
  task automatic wr(input logic [1:0] idle, input logic [7:0] d,
      input logic c);
    host_model_inst.cyc(2'h2, idle, d, 8'hFF, c, q);
  endtask : wr
  // One strap and upper-line code for each of the eight modes against the decoded mode.
  task automatic t_mode;
    logic [6:0] tbl [8] = '{7'h40, 7'h79, 7'h02, 7'h23, 7'h14, 7'h1D,
      7'h36, 7'h3F};
    for (int i = 0; i < 8; i++) begin
      host_model_inst.setMode(tbl[i][6:5], tbl[i][4:3], 2'h3);
      `CHK(activeMode, tbl[i][2:0])
    end
    $display("test mode done");
  endtask : t_mode
  // Writes in both conventions, then one while not selected.
  task automatic t_write;
    host_model_inst.setMode(2'h2, 2'h0, 2'h3);
    host_model_inst.sel(1'h1);
    wr(2'h3, 8'hA5, 1'h0);
    popChk(8'hA5, 1'h0);
    wr(2'h3, 8'h3C, 1'h1);
    popChk(8'h3C, 1'h1);
    host_model_inst.sel(1'h0);
    host_model_inst.setMode(2'h3, 2'h0, 2'h0);
    host_model_inst.sel(1'h1);
    wr(2'h0, 8'h5A, 1'h1);
    popChk(8'h5A, 1'h1);
    host_model_inst.sel(1'h0);
    wr(2'h0, 8'h77, 1'h1);
    repeat (10) @(negedge clk_sys);
    `CHK(hostByteValid, 1'h0)
    $display("test write done");
  endtask : t_write
  // Nibble writes with junk on lines 5:4.
  task automatic t_nib;
    host_model_inst.setMode(2'h0, 2'h0, 2'h3);
    host_model_inst.sel(1'h1);
    wr(2'h3, 8'h36, 1'h1);
    wr(2'h3, 8'h39, 1'h1);
    popChk(8'h69, 1'h1);
    host_model_inst.sel(1'h0);
    $display("test nibble done");
  endtask : t_nib
  // Status and data reads, then a read while not selected.
  task automatic t_read;
    host_model_inst.setMode(2'h2, 2'h0, 2'h3);
    host_model_inst.sel(1'h1);
    host_model_inst.cyc(2'h1, 2'h3, 8'h00, 8'h00, 1'h0, q);
    `CHK(q, {1'h1, 7'h12})
    host_model_inst.cyc(2'h1, 2'h3, 8'h00, 8'h00, 1'h1, q);
    `CHK(q, 8'hC6)
    // Other strap level and other user bytes, so no input stays fixed.
    identityStrap = 1'h0;
    statusBits = 7'h2D;
    readData = 8'h3B;
    host_model_inst.cyc(2'h1, 2'h3, 8'h00, 8'h00, 1'h0, q);
    `CHK(q, {1'h0, 7'h2D})
    host_model_inst.cyc(2'h1, 2'h3, 8'h00, 8'h00, 1'h1, q);
    `CHK(q, 8'h3B)
    host_model_inst.sel(1'h0);
    host_model_inst.cyc(2'h1, 2'h3, 8'h00, 8'h00, 1'h0, q);
    `CHK(q, 8'hFF)
    $display("test read done");
  endtask : t_read
  // Nine-bit frame with the pin opposite, then an eight-bit frame.
  task automatic t_ser;
    host_model_inst.setMode(2'h1, 2'h2, 2'h0);
    host_model_inst.spi(9'h1C3, 9);
    popChk(8'hC3, 1'h1);
    host_model_inst.setMode(2'h0, 2'h2, 2'h3);
    host_model_inst.spi(9'h04B, 8);
    popChk(8'h4B, 1'h0);
    $display("test serial done");
  endtask : t_ser
  // Fills the buffer with the consumer stalled, overflows, drains.
  task automatic t_fifo;
    host_model_inst.setMode(2'h2, 2'h0, 2'h3);
    host_model_inst.sel(1'h1);
    for (int i = 0; i < 17; i++) begin
      wr(2'h3, 8'(i), 1'h1);
    end
    `CHK(overflow, 1'h0)
    wr(2'h3, 8'hEE, 1'h1);
    repeat (4) @(negedge clk_sys);
    `CHK(overflow, 1'h1)
    for (int i = 0; i < 17; i++) begin
      popChk(8'(i), 1'h1);
    end
    `CHK(hostByteValid, 1'h0)
    $display("test buffer done");
  endtask : t_fifo
  // Reset, then the tests in order.
  initial begin
    rst_n = 1'h0;
    hostByteReady = 1'h0;
    identityStrap = 1'h1;
    statusBits = 7'h12;
    readData = 8'hC6;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'h1;
    t_mode();
    t_write();
    t_nib();
    t_read();
    t_ser();
    t_fifo();
    tally_and_finish();
  end
  // Watchdog against a hang.
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
